// file: core/vsd_pkg.sv
// Constants for the VMEbus-side DMA controller: register map, fields,
// controller states and timing counts.
// Assumes a 32-bit APB register bus and a 10 MHz system clock.
package vsd_pkg;
  // ------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] A_DCMD  = 8'h00; // DMA command
  localparam logic [7:0] A_LADR  = 8'h04; // Local DMA address
  localparam logic [7:0] A_RADR  = 8'h08; // Remote DMA address
  localparam logic [7:0] A_LREM  = 8'h0C; // Local remainder count
  localparam logic [7:0] A_RREM  = 8'h10; // Remote remainder count
  localparam logic [7:0] A_PKT   = 8'h14; // Local packet count
  localparam logic [7:0] A_LCMD  = 8'h18; // Local command
  localparam logic [7:0] A_LSTAT = 8'h1C; // Local status
  localparam logic [7:0] A_AM    = 8'h20; // Address modifier
  localparam logic [7:0] A_VEC   = 8'h24; // Interrupt vector
  localparam logic [7:0] A_LVL   = 8'h28; // Interrupt level select
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int DC_BLOCK = 0;
  localparam int DC_DONE  = 1;
  localparam int DC_IEN   = 2;
  localparam int DC_PAUSE = 3;
  localparam int DC_TOVME = 6;
  localparam int DC_START = 7;
  localparam int LC_CLRER = 7;
  localparam int LC_CLRPR = 6;
  localparam int LC_PT    = 5;
  localparam int LC_DISV  = 4;
  localparam int LC_DISA  = 2;
  localparam int LS_DERR  = 7;
  localparam int LS_RBERR = 6;
  localparam int LS_PR    = 5;
  localparam int LS_LRC   = 3;
  localparam int LS_TMO   = 2;
  localparam int LS_PT    = 1;
  localparam int LS_VBERR = 0;
  localparam int PKT_SHIFT = 8;      // Bytes per packet as a shift
  // ------------------------------------------------------------
  // Reset values and tenure limits
  // ------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [8:0]  BLOCK_BYTES = 9'h100;
  localparam logic [8:0]  PAUSE_BYTES = 9'h040;
  localparam logic [23:0] BEAT_BYTES  = 24'h000004;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 10;
  localparam int TMO_US  = 16000;    // DMA completion timeout
  localparam int TMO_CYC = TMO_US * CLK_MHZ;
  // ------------------------------------------------------------
  // Controller states, Gray along the beat path
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_ARB  = 3'h1,
    S_LIN  = 3'h3,
    S_ACC  = 3'h2,
    S_LOUT = 3'h6,
    S_REL  = 3'h7,
    S_DONE = 3'h5
  } vsd_state_t;
endpackage

// file: core/vsd_dma_ctrl.sv
// VMEbus-side DMA controller with completion and interrupt status.
// Assumes APB from the VMEbus master bridge, VMEbus handshake pins
// (asynchronous) and a same-clock link toward the PCI side.
// Operation
// - One DMA at a time across adapter
// - Start on a command write that sets bit 7 over a stored clear bit 7, idle link
// - Block mode: at most 256 bytes/tenure
// - Pause mode: at most 64 bytes/tenure
// - Non-block: rearbitrate after every transfer
// - No remote access during a DMA
// - Address modifier driven on every access
// - Vector supplied on completion acknowledge
// - Enabled completion raises level 1 or 2
// - Disable bit blocks all interrupts to VMEbus
// - Done set on any end, error included
// - Clearing done drops completion request
// - Error flags stay until clear bit
// - Clear bit drops receiver interrupt flag
`timescale 1ns/1ns
`default_nettype none
module vsd_dma_ctrl #(
  parameter int DMA_TIMEOUT_CYC = vsd_pkg::TMO_CYC
) (
  input  wire  logic        mclk,
  input  wire  logic        rst_b,
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [7:0]  paddr,
  input  wire  logic [31:0] pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire  logic        vme_bus_grant,
  input  wire  logic        vme_ack,
  input  wire  logic        vme_berr,
  input  wire  logic        vme_iack,
  input  wire  logic [31:0] vme_rdata,
  output logic              vme_bus_req,
  output logic              vme_strobe,
  output logic              vme_write,
  output logic [31:0]       vme_addr,
  output logic [7:0]        vme_am,
  output logic [31:0]       vme_wdata,
  output logic              vme_irq1,
  output logic              vme_irq2,
  output logic [7:0]        vme_vector,
  input  wire  logic        link_in_valid,
  input  wire  logic [31:0] link_in_data,
  output logic              link_in_ready,
  output logic              link_out_valid,
  output logic [31:0]       link_out_data,
  input  wire  logic        link_out_ready,
  input  wire  logic        link_rbus_err,
  input  wire  logic        link_data_err,
  input  wire  logic        link_lrc_err,
  input  wire  logic        link_pr_set,
  input  wire  logic        link_dma_busy,
  output logic [23:0]       remote_dma_addr,
  output logic [7:0]        remote_dma_rem,
  output logic              pt_irq,
  output logic              remote_inhibit,
  output logic              dma_busy
);
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [3:0] pin_raw;
  logic [3:0] s1_ff;
  logic [3:0] s2_ff;
  assign pin_raw = {vme_iack, vme_berr, vme_ack, vme_bus_grant};
  // Two flops per VMEbus handshake input
  for (genvar i = 0; i < 4; i++) begin : g_sync
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        s1_ff[i] <= 1'b0;
        s2_ff[i] <= 1'b0;
      end else begin
        s1_ff[i] <= pin_raw[i];
        s2_ff[i] <= s1_ff[i];
      end
    end
  end
  logic grant_s;
  logic ack_s;
  logic berr_s;
  logic iack_s;
  assign {iack_s, berr_s, ack_s, grant_s} = s2_ff;

  // ------------------------------------------------------------
  // Register file and APB slave
  // ------------------------------------------------------------
  logic [7:0]  dcmd_ff, nxt_dcmd;
  logic [31:0] ladr_ff, nxt_ladr;
  logic [23:0] radr_ff, nxt_radr;
  logic [7:0]  lrem_ff, nxt_lrem;
  logic [7:0]  rrem_ff, nxt_rrem;
  logic [15:0] pkt_ff, nxt_pkt;
  logic [7:0]  lcmd_ff, nxt_lcmd;
  logic [7:0]  stat_ff, nxt_stat;
  logic [7:0]  am_ff, nxt_am;
  logic [7:0]  vec_ff, nxt_vec;
  logic        lvl_ff, nxt_lvl;
  logic [31:0] prdata_ff, nxt_prdata;
  logic        pready_ff, nxt_pready;
  logic        pslverr_ff, nxt_pslverr;
  logic        wr_en, rd_en, start_go, end_ev, end_err;
  logic [7:0]  err_ev;
  vsd_pkg::vsd_state_t st_ff, nxt_st;

  assign wr_en = psel && penable && !pready_ff && pwrite;
  assign rd_en = psel && penable && !pready_ff && !pwrite;
  // Start only when bit 7 rises over a stored clear value, idle link
  assign start_go = wr_en && paddr == vsd_pkg::A_DCMD
    && pwdata[vsd_pkg::DC_START] && !dcmd_ff[vsd_pkg::DC_START]
    && st_ff == vsd_pkg::S_IDLE && !link_dma_busy;

  // Register writes, hardware status updates and read mux
  always_comb begin
    nxt_dcmd = dcmd_ff;
    nxt_ladr = ladr_ff;
    nxt_radr = radr_ff;
    nxt_lrem = lrem_ff;
    nxt_rrem = rrem_ff;
    nxt_pkt  = pkt_ff;
    nxt_lcmd = lcmd_ff;
    nxt_stat = stat_ff;
    nxt_am   = am_ff;
    nxt_vec  = vec_ff;
    nxt_lvl  = lvl_ff;
    nxt_prdata  = prdata_ff;
    nxt_pslverr = 1'b0;
    nxt_pready  = psel && penable && !pready_ff;
    if (wr_en) begin
      unique case (paddr)
        vsd_pkg::A_DCMD: begin
          // Done is cleared by software, never set by it
          nxt_dcmd = {pwdata[7:2],
                      dcmd_ff[vsd_pkg::DC_DONE] & pwdata[vsd_pkg::DC_DONE],
                      pwdata[0]};
          // A refused start must not leave bit 7 stored as set
          if (st_ff != vsd_pkg::S_IDLE || link_dma_busy) begin
            nxt_dcmd[vsd_pkg::DC_START] = dcmd_ff[vsd_pkg::DC_START];
          end
        end
        vsd_pkg::A_LADR: nxt_ladr = pwdata;
        vsd_pkg::A_RADR: nxt_radr = pwdata[23:0];
        vsd_pkg::A_LREM: nxt_lrem = pwdata[7:0];
        vsd_pkg::A_RREM: nxt_rrem = pwdata[7:0];
        vsd_pkg::A_PKT:  nxt_pkt  = pwdata[15:0];
        vsd_pkg::A_LCMD: begin
          nxt_lcmd = {2'b00, pwdata[5:0]};
          if (pwdata[vsd_pkg::LC_CLRER]) begin
            nxt_stat = stat_ff & 8'h32;
          end
          if (pwdata[vsd_pkg::LC_CLRPR]) begin
            nxt_stat[vsd_pkg::LS_PR] = 1'b0;
          end
        end
        vsd_pkg::A_AM:   nxt_am  = pwdata[7:0];
        vsd_pkg::A_VEC:  nxt_vec = pwdata[7:0];
        vsd_pkg::A_LVL:  nxt_lvl = pwdata[0];
        vsd_pkg::A_LSTAT: nxt_prdata = prdata_ff;
        default: nxt_pslverr = 1'b1;
      endcase
    end
    if (rd_en) begin
      unique case (paddr)
        vsd_pkg::A_DCMD:  nxt_prdata = {24'h000000, dcmd_ff};
        vsd_pkg::A_LADR:  nxt_prdata = ladr_ff;
        vsd_pkg::A_RADR:  nxt_prdata = {8'h00, radr_ff};
        vsd_pkg::A_LREM:  nxt_prdata = {24'h000000, lrem_ff};
        vsd_pkg::A_RREM:  nxt_prdata = {24'h000000, rrem_ff};
        vsd_pkg::A_PKT:   nxt_prdata = {16'h0000, pkt_ff};
        vsd_pkg::A_LCMD:  nxt_prdata = {24'h000000, lcmd_ff};
        vsd_pkg::A_LSTAT: nxt_prdata = {24'h000000, stat_ff};
        vsd_pkg::A_AM:    nxt_prdata = {24'h000000, am_ff};
        vsd_pkg::A_VEC:   nxt_prdata = {24'h000000, vec_ff};
        vsd_pkg::A_LVL:   nxt_prdata = {31'h00000000, lvl_ff};
        default: begin
          nxt_prdata  = 32'h00000000;
          nxt_pslverr = 1'b1;
        end
      endcase
    end
    // Hardware events win over a same-cycle software clear
    nxt_stat = nxt_stat | err_ev;
    nxt_stat[vsd_pkg::LS_PT] = lcmd_ff[vsd_pkg::LC_PT];
    if (end_ev) begin
      nxt_dcmd[vsd_pkg::DC_DONE]  = 1'b1;
      nxt_dcmd[vsd_pkg::DC_START] = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dcmd_ff <= vsd_pkg::RST_BYTE;
      ladr_ff <= 32'h00000000;
      radr_ff <= 24'h000000;
      lrem_ff <= vsd_pkg::RST_BYTE;
      rrem_ff <= vsd_pkg::RST_BYTE;
      pkt_ff  <= 16'h0000;
      lcmd_ff <= vsd_pkg::RST_BYTE;
      stat_ff <= vsd_pkg::RST_BYTE;
      am_ff   <= vsd_pkg::RST_BYTE;
      vec_ff  <= vsd_pkg::RST_BYTE;
      lvl_ff  <= 1'b0;
      prdata_ff  <= 32'h00000000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      dcmd_ff <= nxt_dcmd;
      ladr_ff <= nxt_ladr;
      radr_ff <= nxt_radr;
      lrem_ff <= nxt_lrem;
      rrem_ff <= nxt_rrem;
      pkt_ff  <= nxt_pkt;
      lcmd_ff <= nxt_lcmd;
      stat_ff <= nxt_stat;
      am_ff   <= nxt_am;
      vec_ff  <= nxt_vec;
      lvl_ff  <= nxt_lvl;
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // ------------------------------------------------------------
  // Transfer engine
  // ------------------------------------------------------------
  logic [23:0] left_ff, nxt_left;
  logic [8:0]  ten_ff, nxt_ten;
  logic [31:0] addr_ff, nxt_addr;
  logic [31:0] data_ff, nxt_data;
  logic [31:0] tmo_ff, nxt_tmo;
  logic        req_ff, nxt_req, stb_ff, nxt_stb;
  logic        tovme, last_beat;
  logic [8:0]  ten_lim;
  logic [23:0] beat;

  assign tovme = dcmd_ff[vsd_pkg::DC_TOVME];
  assign beat  = (left_ff < vsd_pkg::BEAT_BYTES) ? left_ff : vsd_pkg::BEAT_BYTES;
  assign last_beat = left_ff == beat;
  // Tenure limit per arbitration mode
  always_comb begin
    if (!dcmd_ff[vsd_pkg::DC_BLOCK]) begin
      ten_lim = 9'(beat);
    end else if (dcmd_ff[vsd_pkg::DC_PAUSE]) begin
      ten_lim = vsd_pkg::PAUSE_BYTES;
    end else begin
      ten_lim = vsd_pkg::BLOCK_BYTES;
    end
  end

  // Beat sequencing, error capture and completion
  always_comb begin
    nxt_st   = st_ff;
    nxt_left = left_ff;
    nxt_ten  = ten_ff;
    nxt_addr = addr_ff;
    nxt_data = data_ff;
    nxt_req  = req_ff;
    nxt_stb  = 1'b0;
    nxt_tmo  = (st_ff == vsd_pkg::S_IDLE) ? 32'h00000000 : tmo_ff + 32'h00000001;
    err_ev   = 8'h00;
    err_ev[vsd_pkg::LS_RBERR] = link_rbus_err;
    err_ev[vsd_pkg::LS_DERR]  = link_data_err;
    err_ev[vsd_pkg::LS_LRC]   = link_lrc_err;
    err_ev[vsd_pkg::LS_PR]    = link_pr_set;
    end_ev  = 1'b0;
    end_err = |{link_rbus_err, link_data_err, link_lrc_err};
    unique case (st_ff)
      vsd_pkg::S_IDLE: if (start_go) begin
        nxt_left = {pkt_ff, lrem_ff}; // Packets of 256 plus remainder
        nxt_addr = ladr_ff;
        nxt_st   = (pkt_ff == 16'h0000 && lrem_ff == 8'h00)
                   ? vsd_pkg::S_DONE : vsd_pkg::S_ARB;
      end
      vsd_pkg::S_ARB: begin
        // Request again only once the old grant is gone, so a stale grant cannot pass
        nxt_req = req_ff || !grant_s;
        nxt_ten = 9'h000;
        if (grant_s && req_ff) begin
          nxt_st = tovme ? vsd_pkg::S_LIN : vsd_pkg::S_ACC;
        end
      end
      vsd_pkg::S_LIN: if (link_in_valid) begin
        nxt_data = link_in_data;
        nxt_st   = vsd_pkg::S_ACC;
      end
      vsd_pkg::S_ACC: begin
        // Strobe only after the previous acknowledge has been released
        nxt_stb = !(ack_s || berr_s);
        if (stb_ff && berr_s) begin
          err_ev[vsd_pkg::LS_VBERR] = 1'b1;
          nxt_st = vsd_pkg::S_REL;
          nxt_left = 24'h000000;
        end else if (stb_ff && ack_s) begin
          if (!tovme) begin
            nxt_data = vme_rdata;
          end
          nxt_st = tovme ? vsd_pkg::S_REL : vsd_pkg::S_LOUT;
        end
      end
      vsd_pkg::S_LOUT: if (link_out_ready) begin
        nxt_st = vsd_pkg::S_REL;
      end
      vsd_pkg::S_REL: begin
        // Count the beat, then keep or give up the bus
        nxt_left = left_ff - beat;
        nxt_addr = addr_ff + 32'(beat);
        nxt_ten  = ten_ff + 9'(beat);
        if (left_ff == 24'h000000 || last_beat) begin
          nxt_st  = vsd_pkg::S_DONE;
          nxt_req = 1'b0;
        end else if (ten_ff + 9'(beat) + 9'(beat) > ten_lim) begin
          nxt_st  = vsd_pkg::S_ARB;
          nxt_req = 1'b0;
        end else begin
          nxt_st  = tovme ? vsd_pkg::S_LIN : vsd_pkg::S_ACC;
        end
      end
      vsd_pkg::S_DONE: begin
        end_ev = 1'b1;
        nxt_req = 1'b0;
        nxt_st = vsd_pkg::S_IDLE;
      end
      default: nxt_st = vsd_pkg::S_IDLE;
    endcase
    // Timeout or link error aborts and still reports done
    if (st_ff != vsd_pkg::S_IDLE && st_ff != vsd_pkg::S_DONE
        && (end_err || tmo_ff >= 32'(DMA_TIMEOUT_CYC))) begin
      err_ev[vsd_pkg::LS_TMO] = !end_err;
      nxt_st  = vsd_pkg::S_DONE;
      nxt_req = 1'b0;
      nxt_stb = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff   <= vsd_pkg::S_IDLE;
      left_ff <= 24'h000000;
      ten_ff  <= 9'h000;
      addr_ff <= 32'h00000000;
      data_ff <= 32'h00000000;
      tmo_ff  <= 32'h00000000;
      req_ff  <= 1'b0;
      stb_ff  <= 1'b0;
    end else begin
      st_ff   <= nxt_st;
      left_ff <= nxt_left;
      ten_ff  <= nxt_ten;
      addr_ff <= nxt_addr;
      data_ff <= nxt_data;
      tmo_ff  <= nxt_tmo;
      req_ff  <= nxt_req;
      stb_ff  <= nxt_stb;
    end
  end

  // ------------------------------------------------------------
  // Interrupt requests, vector and link-facing flags
  // ------------------------------------------------------------
  logic irq1_ff, irq2_ff, busy_ff, vecv, pt_ff, nxt_irq;
  logic [7:0] vout_ff;
  // Completion only when done and enabled; disable bit gates all
  assign nxt_irq = ((dcmd_ff[vsd_pkg::DC_DONE] && dcmd_ff[vsd_pkg::DC_IEN])
    || (|(stat_ff & 8'hEC))) && !lcmd_ff[vsd_pkg::LC_DISV];
  assign vecv = iack_s && (irq1_ff || irq2_ff);
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq1_ff <= 1'b0;
      irq2_ff <= 1'b0;
      busy_ff <= 1'b0;
      pt_ff   <= 1'b0;
      vout_ff <= vsd_pkg::RST_BYTE;
    end else begin
      irq1_ff <= nxt_irq && !lvl_ff;
      irq2_ff <= nxt_irq && lvl_ff;
      busy_ff <= nxt_st != vsd_pkg::S_IDLE;
      pt_ff   <= lcmd_ff[vsd_pkg::LC_PT] && !lcmd_ff[vsd_pkg::LC_DISA];
      vout_ff <= vecv ? vec_ff : vsd_pkg::RST_BYTE;
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign vme_bus_req = req_ff;
  assign vme_strobe  = stb_ff;
  assign vme_write   = tovme;
  assign vme_addr    = addr_ff;
  assign vme_am      = am_ff;
  assign vme_wdata   = data_ff;
  assign vme_irq1    = irq1_ff;
  assign vme_irq2    = irq2_ff;
  assign vme_vector  = vout_ff;
  assign link_in_ready  = st_ff == vsd_pkg::S_LIN;
  assign link_out_valid = st_ff == vsd_pkg::S_LOUT;
  assign link_out_data  = data_ff;
  assign remote_dma_addr = radr_ff;
  assign remote_dma_rem  = rrem_ff;
  assign pt_irq         = pt_ff;
  assign remote_inhibit = busy_ff;
  assign dma_busy       = busy_ff;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  chk_no_restart: assert property (st_ff != vsd_pkg::S_IDLE |-> !start_go)
    else $error("start taken while busy");
  chk_start_edge: assert property (start_go |-> !dcmd_ff[vsd_pkg::DC_START])
    else $error("start without prior clear write");
  chk_block_ten: assert property (st_ff == vsd_pkg::S_ACC && !dcmd_ff[vsd_pkg::DC_PAUSE]
    |-> ten_ff < vsd_pkg::BLOCK_BYTES) else $error("block tenure too long");
  chk_pause_ten: assert property (st_ff == vsd_pkg::S_ACC && dcmd_ff[vsd_pkg::DC_PAUSE]
    && dcmd_ff[vsd_pkg::DC_BLOCK] |-> ten_ff < vsd_pkg::PAUSE_BYTES) else $error("pause tenure too long");
  chk_nonblk_rel: assert property (st_ff == vsd_pkg::S_REL && !dcmd_ff[vsd_pkg::DC_BLOCK]
    |=> !req_ff) else $error("bus kept in non-block mode");
  chk_busy_inhib: assert property (st_ff == vsd_pkg::S_ACC |-> remote_inhibit)
    else $error("remote access open during DMA");
  chk_done_set: assert property (st_ff == vsd_pkg::S_DONE |=> dcmd_ff[vsd_pkg::DC_DONE])
    else $error("done flag not set at end");
  chk_irq_drop: assert property (!dcmd_ff[vsd_pkg::DC_DONE] && !(|(stat_ff & 8'hEC))
    ##1 !dcmd_ff[vsd_pkg::DC_DONE] |-> !vme_irq1 && !vme_irq2) else $error("irq without source");
  chk_irq_block: assert property (lcmd_ff[vsd_pkg::LC_DISV] |=> !vme_irq1 && !vme_irq2)
    else $error("irq passed while disabled");
  chk_irq_raise: assert property (dcmd_ff[vsd_pkg::DC_DONE] && dcmd_ff[vsd_pkg::DC_IEN]
    && !lcmd_ff[vsd_pkg::LC_DISV] |=> vme_irq1 || vme_irq2) else $error("completion irq missing");
  chk_err_hold: assert property (stat_ff[vsd_pkg::LS_DERR]
    && !(wr_en && paddr == vsd_pkg::A_LCMD && pwdata[vsd_pkg::LC_CLRER])
    |=> stat_ff[vsd_pkg::LS_DERR]) else $error("error flag lost");
  cov_block_run: cover property (start_go && pwdata[vsd_pkg::DC_BLOCK] ##[1:600] st_ff == vsd_pkg::S_DONE);
  cov_to_vme: cover property (st_ff == vsd_pkg::S_LIN ##[1:20] st_ff == vsd_pkg::S_ACC);
  cov_vector: cover property (vecv);
endmodule
`default_nettype wire

// file: sim/vsd_vme_mem.sv
// VMEbus memory and arbiter model facing the DMA controller.
// Assumes one clock; it samples requests on the rising edge.
`timescale 1ns/1ns
`default_nettype none
module vsd_vme_mem (
  input  wire  logic        mclk,
  input  wire  logic        clr,
  input  wire  logic        bus_req,
  input  wire  logic        strobe,
  output logic              grant,
  output logic              ack,
  output logic [31:0]       rdata,
  output int                tenures,
  output int                maxb
);
  logic [1:0] gd = 2'h0;
  logic       stb_q = 1'b0;
  int         beats = 0;
  int         ackc = 0;
  initial begin
    {grant, ack} = 2'h0;
    rdata = 32'h00000000;
    tenures = 0;
    maxb = 0;
  end
  // Grant trails the request; each strobe gets a short ack; data inverts once released
  always @(posedge mclk) begin
    gd <= {gd[0], bus_req};
    grant <= gd[1] & bus_req;
    ackc <= strobe ? 4 : (ackc > 0 ? ackc - 1 : 0);
    ack <= (ackc > 1);
    rdata <= ack ? 32'hA5A50000 + beats : ~rdata;
    // The strobe stands until acknowledged: count each access once, on its rise
    stb_q <= strobe;
    if (strobe && !stb_q)
      beats <= beats + 1;
    // Tally beats of each tenure when the request drops
    if (!bus_req && gd[0]) begin
      tenures <= tenures + 1;
      maxb <= beats > maxb ? beats : maxb;
      beats <= 0;
    end
    if (clr) begin
      tenures <= 0;
      maxb <= 0;
    end
  end
endmodule
`default_nettype wire

// file: sim/tb.sv
// Bench for the VMEbus-side DMA controller: registers, modes, status.
// Assumes the memory model answers every tenure and strobe.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        mclk, rst_b, psel, penable, pwrite, iack, pr_set, dat_err, lrc_err, lbusy, clr, perr;
  logic        pready, pslverr, req, stb, grant, ack, irq1, irq2, pt, busy;
  logic [7:0]  paddr, vec, am, rrem;
  logic [23:0] radr;
  logic [31:0] pwdata, prdata, rdata, r;
  int          mismatches, n_compared, tenures, maxb;
  vsd_dma_ctrl #(.DMA_TIMEOUT_CYC(5000)) u_dut (
    .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .vme_bus_grant(grant),
    .vme_ack(ack), .vme_berr(1'b0), .vme_iack(iack), .vme_rdata(rdata), .vme_bus_req(req),
    .vme_strobe(stb), .vme_write(), .vme_addr(), .vme_am(am), .vme_wdata(), .vme_irq1(irq1),
    .vme_irq2(irq2), .vme_vector(vec), .link_in_valid(1'b0), .link_in_data(32'h00000000),
    .link_in_ready(), .link_out_valid(), .link_out_data(), .link_out_ready(1'b1),
    .link_rbus_err(dat_err), .link_data_err(dat_err), .link_lrc_err(lrc_err), .link_pr_set(pr_set),
    .link_dma_busy(lbusy), .remote_dma_addr(radr), .remote_dma_rem(rrem), .pt_irq(pt), .remote_inhibit(),
    .dma_busy(busy));
  vsd_vme_mem u_mem (.mclk(mclk), .clr(clr), .bus_req(req), .strobe(stb), .grant(grant), .ack(ack),
    .rdata(rdata), .tenures(tenures), .maxb(maxb));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // One APB transfer, held until pready, then an idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string m);
    apb(1'b0, a, 32'h00000000);
    chk(r, exp, m);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    apb(1'b1, vsd_pkg::A_AM, 32'h0000003D);
    rd(vsd_pkg::A_AM, 32'h0000003D, "am");
    rd(8'h40, 32'h00000000, "unmapped");
    chk({31'h0, perr}, 32'h00000001, "slverr");
    apb(1'b1, vsd_pkg::A_VEC, 32'h0000005A);
    lbusy <= 1'b1;
    apb(1'b1, vsd_pkg::A_DCMD, 32'h00000080);
    chk({31'h0, busy}, 32'h00000000, "refused");
    rd(vsd_pkg::A_DCMD, 32'h00000000, "start bit dropped");
    lbusy <= 1'b0;
  endtask
  task automatic t_dma(input logic [31:0] cmd, pkt, rem, tn, mx);
    int n;
    n = 0;
    clr <= 1'b1;
    apb(1'b1, vsd_pkg::A_DCMD, cmd);
    chk({31'h0, busy}, 32'h00000000, "first write");
    clr <= 1'b0;
    apb(1'b1, vsd_pkg::A_RADR, 32'h00003010);
    apb(1'b1, vsd_pkg::A_LREM, rem);
    apb(1'b1, vsd_pkg::A_RREM, rem);
    apb(1'b1, vsd_pkg::A_PKT, pkt);
    apb(1'b1, vsd_pkg::A_LCMD, 32'h00000004);
    apb(1'b1, vsd_pkg::A_DCMD, cmd | 32'h00000080);
    do begin
      apb(1'b0, vsd_pkg::A_DCMD, 32'h00000000);
      n++;
    end while (r[1] !== 1'b1 && n < 2000);
    chk(r & 32'h00000083, (cmd & 32'h00000001) | 32'h00000002, "done");
    chk(tenures, tn, "tenures");
    chk({8'h00, radr}, 32'h00003010, "remote addr");
    chk({24'h0, rrem}, rem, "remote rem");
    chk({24'h0, am}, 32'h0000003D, "am pins");
    chk(maxb, mx, "beats per tenure");
  endtask
  task automatic t_irq();
    repeat (3) @(posedge mclk);
    chk({31'h0, irq1}, 32'h00000001, "irq1");
    rd(vsd_pkg::A_DCMD, 32'h00000006, "done and enable");
    iack <= 1'b1;
    repeat (4) @(posedge mclk);
    chk({24'h0, vec}, 32'h0000005A, "vector");
    apb(1'b1, vsd_pkg::A_LVL, 32'h00000001);
    chk({30'h0, irq2, irq1}, 32'h00000002, "level 2");
    apb(1'b1, vsd_pkg::A_LVL, 32'h00000000);
    iack <= 1'b0;
    apb(1'b1, vsd_pkg::A_DCMD, 32'h00000004);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq1}, 32'h00000000, "irq drop");
  endtask
  task automatic t_status();
    apb(1'b1, vsd_pkg::A_LCMD, 32'h00000010);
    {dat_err, lrc_err} <= 2'h3;
    @(posedge mclk);
    {dat_err, lrc_err} <= 2'h0;
    rd(vsd_pkg::A_LSTAT, 32'h000000C8, "errors");
    chk({31'h0, irq1}, 32'h00000000, "masked");
    apb(1'b1, vsd_pkg::A_LCMD, 32'h00000000);
    rd(vsd_pkg::A_LSTAT, 32'h000000C8, "held");
    chk({31'h0, irq1}, 32'h00000001, "unmasked");
    apb(1'b1, vsd_pkg::A_LCMD, 32'h00000080);
    rd(vsd_pkg::A_LSTAT, 32'h00000000, "cleared");
    pr_set <= 1'b1;
    @(posedge mclk);
    pr_set <= 1'b0;
    rd(vsd_pkg::A_LSTAT, 32'h00000020, "pr set");
    apb(1'b1, vsd_pkg::A_LCMD, 32'h00000040);
    rd(vsd_pkg::A_LSTAT, 32'h00000000, "pr clear");
    apb(1'b1, vsd_pkg::A_LCMD, 32'h00000020);
    rd(vsd_pkg::A_LSTAT, 32'h00000002, "pt status");
    chk({31'h0, pt}, 32'h00000001, "pt sent");
    apb(1'b1, vsd_pkg::A_LCMD, 32'h00000000);
  endtask
  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Clock, 100 ns period
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (60000) @(posedge mclk);
    mismatches++;
    print_verdict();
  end
  // Main sequence
  initial begin
    {rst_b, psel, penable, pwrite, iack, pr_set, dat_err, lrc_err, lbusy, clr, perr} = 11'h000;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    mismatches = 0;
    n_compared = 0;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_dma(32'h00000004, 32'h00000000, 32'h00000008, 2, 1);
    t_irq();
    t_dma(32'h00000009, 32'h00000000, 32'h00000080, 2, 16);
    t_dma(32'h00000001, 32'h00000001, 32'h00000040, 2, 64);
    t_status();
    print_verdict();
  end
endmodule
`default_nettype wire
